/* pkg/ubd_pkg.sv */
// Purpose: Shared constants and helpers for the UART divisor block
// Assumes: 40 MHz system clock, Avalon-MM byte addresses
// Notes:   All offsets are byte addresses of 32-bit words
package ubd_pkg;

	// ==================================================================
	// Register map
	localparam logic [7:0] OFS_ILP = 8'h20;
	localparam logic [7:0] OFS_IBRD = 8'h24;
	localparam logic [7:0] OFS_FBRD = 8'h28;
	localparam logic [7:0] OFS_LCTL = 8'h2c;
	localparam logic [7:0] OFS_IRCTL = 8'h30;
	localparam logic [7:0] OFS_STAT = 8'h34;
	localparam logic [7:0] OFS_ACT = 8'h38;

	// ==================================================================
	// Reset values
	localparam logic [7:0] ILP_RST = 8'h00;
	localparam logic [15:0] IBRD_RST = 16'h0000;
	localparam logic [5:0] FBRD_RST = 6'h00;
	localparam logic [7:0] LCTL_RST = 8'h00;
	localparam logic [1:0] IRCTL_RST = 2'h0;

	// ==================================================================
	// Field positions
	localparam int IRCTL_SIR_BIT = 0;
	localparam int IRCTL_LP_BIT = 1;
	localparam int STAT_PEND_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_IRTX_BIT = 2;
	localparam int STAT_LPOFF_BIT = 3;
	localparam int ACT_FRAC_LSB = 16;

	// ==================================================================
	// Timing
	localparam int SYS_CLK_MHZ = 40;
	localparam int RX_ACCEPT_NS = 1400;
	localparam logic [7:0] RX_ACCEPT_CYC =
		8'((RX_ACCEPT_NS * SYS_CLK_MHZ) / 1000);
	localparam logic [1:0] IR_PULSE_TICKS = 2'h3;
	localparam logic [21:0] FRAC_STEP = 22'h000040;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARM = 2'h1,
		ST_PULSE = 2'h3
	} ubd_pulse_e;

	// Byte-lane merge for a write with byte enables
	function automatic logic [7:0] ubd_be_merge(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic be);
		ubd_be_merge = be ? new_v : old_v;
	endfunction

endpackage

/* logic/ubd_lp_div.sv */
// Purpose: Low-power x16 tick from the system clock
// Assumes: Divisor changes are rare; counter restarts at once when at or past the end
// Notes:   Divisor zero stops the tick completely
`timescale 1ns/1ps
`default_nettype none
module ubd_lp_div
	import ubd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Control
	input wire logic [7:0] divisor_in,
	// Tick
	output logic tick_out
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic nxt_tick;
	wire div_off = (divisor_in == 8'h00);
	wire at_end = (cnt_ff >= divisor_in - 8'h01);

	assign nxt_cnt = (div_off || at_end) ? 8'h00 : cnt_ff + 8'h01;
	assign nxt_tick = ~div_off & at_end;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_ff <= 8'h00;
			tick_out <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_out <= nxt_tick;
		end
	end
endmodule
`default_nettype wire

/* logic/ubd_frac_baud.sv */
// Purpose: Fractional x16 baud tick generator
// Assumes: Divisor is held stable by the caller between loads
// Notes:   Period averages integer plus fraction/64 system clocks
`timescale 1ns/1ps
`default_nettype none
module ubd_frac_baud
	import ubd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Active divisor
	input wire logic [15:0] int_in,
	input wire logic [5:0] frac_in,
	// Tick
	output logic tick_out
);
	logic [21:0] acc_ff;
	logic [21:0] nxt_acc;
	logic nxt_tick;
	wire [21:0] period = {int_in, frac_in};
	wire [21:0] sum = acc_ff + FRAC_STEP;
	wire min_div = (int_in == 16'h0000);
	wire wrap = (sum >= period);

	// Integer zero means divide by one; fraction ignored
	assign nxt_tick = min_div | wrap;
	assign nxt_acc = min_div ? 22'h000000 : (wrap ? sum - period : sum);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			acc_ff <= 22'h000000;
			tick_out <= 1'b0;
		end else begin
			acc_ff <= nxt_acc;
			tick_out <= nxt_tick;
		end
	end
endmodule
`default_nettype wire

/* logic/ubd_divisors.sv */
// Purpose: UART divisor registers, baud and IR low-power timing
// Assumes: Avalon-MM slave, one wait cycle per access
// Notes:   Divisors load into the generator only after a line
//          control write and once the current character is done
//
// Functional notes
// - 8-bit low-power divisor register, reset zero
// - Low-power x16 clock divides system clock
// - Low-power IR pulse lasts three ticks
// - Low-power receiver rejects short, accepts long pulses
// - Divisor zero gives no low-power ticks
// - 16-bit integer divisor, upper bits zero
// - Integer zero divides by one, no fraction
// - 6-bit fraction divisor, upper bits zero
// - New divisor waits for character end
// - Line control write strobes divisor load
`timescale 1ns/1ps
`default_nettype none
module ubd_divisors
	import ubd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Character activity from the serial engine
	input wire logic tx_busy_in,
	input wire logic rx_busy_in,
	input wire logic ir_zero_bit_in,
	// Infrared line
	input wire logic ir_rx_in,
	output logic ir_tx_out,
	output logic ir_rx_valid_out,
	// Timing ticks and line control to the serial engine
	output logic baud_x16_tick_out,
	output logic low_power_x16_tick_out,
	output logic [7:0] line_control_out
);

	// ==================================================================
	// Bus handshake
	logic wait_ff;
	logic nxt_wait;
	logic [31:0] nxt_rdata;
	logic [31:0] rdata_ff;

	wire bus_req = avs_read_in | avs_write_in;
	// Commit only on the edge where waitrequest is seen low
	wire bus_commit = bus_req & ~wait_ff;
	wire wr_commit = avs_write_in & ~wait_ff;
	wire sel_ilp = (avs_address_in == OFS_ILP);
	wire sel_ibrd = (avs_address_in == OFS_IBRD);
	wire sel_fbrd = (avs_address_in == OFS_FBRD);
	wire sel_lctl = (avs_address_in == OFS_LCTL);
	wire sel_irctl = (avs_address_in == OFS_IRCTL);
	wire sel_stat = (avs_address_in == OFS_STAT);
	wire sel_act = (avs_address_in == OFS_ACT);

	assign nxt_wait = ~(bus_req & wait_ff);

	// ==================================================================
	// Software registers
	logic [7:0] ilp_ff;
	logic [15:0] ibrd_ff;
	logic [5:0] fbrd_ff;
	logic [7:0] lctl_ff;
	logic [1:0] irctl_ff;
	logic [7:0] nxt_ilp;
	logic [15:0] nxt_ibrd;
	logic [5:0] nxt_fbrd;
	logic [7:0] nxt_lctl;
	logic [1:0] nxt_irctl;

	wire wr_ilp = wr_commit & sel_ilp;
	wire wr_ibrd = wr_commit & sel_ibrd;
	wire wr_fbrd = wr_commit & sel_fbrd;
	wire wr_lctl = wr_commit & sel_lctl;
	wire wr_irctl = wr_commit & sel_irctl;

	assign nxt_ilp = wr_ilp ? ubd_be_merge(ilp_ff,
		avs_writedata_in[7:0], avs_byteenable_in[0]) : ilp_ff;
	assign nxt_ibrd[7:0] = wr_ibrd ? ubd_be_merge(ibrd_ff[7:0],
		avs_writedata_in[7:0], avs_byteenable_in[0]) :
		ibrd_ff[7:0];
	assign nxt_ibrd[15:8] = wr_ibrd ? ubd_be_merge(ibrd_ff[15:8],
		avs_writedata_in[15:8], avs_byteenable_in[1]) :
		ibrd_ff[15:8];
	assign nxt_fbrd = (wr_fbrd && avs_byteenable_in[0]) ?
		avs_writedata_in[5:0] : fbrd_ff;
	assign nxt_lctl = wr_lctl ? ubd_be_merge(lctl_ff,
		avs_writedata_in[7:0], avs_byteenable_in[0]) : lctl_ff;
	assign nxt_irctl = (wr_irctl && avs_byteenable_in[0]) ?
		avs_writedata_in[1:0] : irctl_ff;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ilp_ff <= ILP_RST;
			ibrd_ff <= IBRD_RST;
			fbrd_ff <= FBRD_RST;
			lctl_ff <= LCTL_RST;
			irctl_ff <= IRCTL_RST;
		end else begin
			ilp_ff <= nxt_ilp;
			ibrd_ff <= nxt_ibrd;
			fbrd_ff <= nxt_fbrd;
			lctl_ff <= nxt_lctl;
			irctl_ff <= nxt_irctl;
		end
	end

	// ==================================================================
	// Divisor load path
	logic pend_ff;
	logic nxt_pend;
	logic [15:0] act_int_ff;
	logic [5:0] act_frac_ff;
	logic [15:0] nxt_act_int;
	logic [5:0] nxt_act_frac;

	wire char_busy = tx_busy_in | rx_busy_in;
	// Divisor writes alone never reach the generator
	wire do_load = pend_ff & ~char_busy;

	// A fresh strobe in the load cycle keeps the request alive
	assign nxt_pend = wr_lctl | (pend_ff & ~do_load);
	assign nxt_act_int = do_load ? ibrd_ff : act_int_ff;
	assign nxt_act_frac = do_load ? fbrd_ff : act_frac_ff;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pend_ff <= 1'b0;
			act_int_ff <= IBRD_RST;
			act_frac_ff <= FBRD_RST;
		end else begin
			pend_ff <= nxt_pend;
			act_int_ff <= nxt_act_int;
			act_frac_ff <= nxt_act_frac;
		end
	end

	// ==================================================================
	// Tick generators
	ubd_frac_baud u_baud (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.int_in(act_int_ff),
		.frac_in(act_frac_ff),
		.tick_out(baud_x16_tick_out)
	);

	// Low-power divisor takes effect at once; it has no load strobe
	ubd_lp_div u_lp (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.divisor_in(ilp_ff),
		.tick_out(low_power_x16_tick_out)
	);

	// ==================================================================
	// IR transmit pulse
	ubd_pulse_e state_ff;
	ubd_pulse_e nxt_state;
	logic [1:0] tick_cnt_ff;
	logic [1:0] nxt_tick_cnt;
	logic nxt_ir_tx;

	wire sir_en = irctl_ff[IRCTL_SIR_BIT];
	wire lp_mode = irctl_ff[IRCTL_LP_BIT];
	// Low-power mode times the pulse on its own tick
	wire pulse_tick = lp_mode ? low_power_x16_tick_out :
		baud_x16_tick_out;
	wire last_tick = pulse_tick & (tick_cnt_ff == IR_PULSE_TICKS - 2'h1);

	always_comb begin
		nxt_state = state_ff;
		nxt_tick_cnt = tick_cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (sir_en && ir_zero_bit_in) begin
					nxt_state = ST_ARM;
				end
			end
			// Align pulse start to a tick edge
			ST_ARM: begin
				if (!sir_en) begin
					nxt_state = ST_IDLE;
				end else if (pulse_tick) begin
					nxt_state = ST_PULSE;
					nxt_tick_cnt = 2'h0;
				end
			end
			ST_PULSE: begin
				if (last_tick) begin
					nxt_state = ST_IDLE;
					nxt_tick_cnt = 2'h0;
				end else if (pulse_tick) begin
					nxt_tick_cnt = tick_cnt_ff + 2'h1;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_tick_cnt = 2'h0;
			end
		endcase
	end

	assign nxt_ir_tx = (nxt_state == ST_PULSE);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff <= ST_IDLE;
			tick_cnt_ff <= 2'h0;
			ir_tx_out <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tick_cnt_ff <= nxt_tick_cnt;
			ir_tx_out <= nxt_ir_tx;
		end
	end

	// ==================================================================
	// IR receive pulse filter
	logic [7:0] hi_cnt_ff;
	logic [7:0] nxt_hi_cnt;
	logic nxt_rx_valid;

	// Threshold is one low-power period, capped at the accept time
	wire [7:0] rx_thresh = (ilp_ff == 8'h00 || ilp_ff > RX_ACCEPT_CYC) ?
		RX_ACCEPT_CYC : ilp_ff;
	wire hi_sat = (hi_cnt_ff == 8'hff);

	assign nxt_hi_cnt = !ir_rx_in ? 8'h00 :
		(hi_sat ? hi_cnt_ff : hi_cnt_ff + 8'h01);
	// Normal mode passes the line straight through
	assign nxt_rx_valid = ir_rx_in & (~lp_mode |
		({1'b0, hi_cnt_ff} + 9'h001 >= {1'b0, rx_thresh}));

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hi_cnt_ff <= 8'h00;
			ir_rx_valid_out <= 1'b0;
		end else begin
			hi_cnt_ff <= nxt_hi_cnt;
			ir_rx_valid_out <= nxt_rx_valid;
		end
	end

	// ==================================================================
	// Read mux
	wire [31:0] stat_word = {28'h0000000, (ilp_ff == 8'h00),
		ir_tx_out, char_busy, pend_ff};
	wire [31:0] act_word = {10'h000, act_frac_ff, act_int_ff};

	always_comb begin
		nxt_rdata = 32'h00000000;
		if (sel_ilp) begin
			nxt_rdata = {24'h000000, ilp_ff};
		end else if (sel_ibrd) begin
			nxt_rdata = {16'h0000, ibrd_ff};
		end else if (sel_fbrd) begin
			nxt_rdata = {26'h0000000, fbrd_ff};
		end else if (sel_lctl) begin
			nxt_rdata = {24'h000000, lctl_ff};
		end else if (sel_irctl) begin
			nxt_rdata = {30'h00000000, irctl_ff};
		end else if (sel_stat) begin
			nxt_rdata = stat_word;
		end else if (sel_act) begin
			nxt_rdata = act_word;
		end
	end

	// Data is captured in the wait cycle and held until the next read
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
		end else begin
			wait_ff <= nxt_wait;
			if (avs_read_in && wait_ff) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	assign avs_waitrequest_out = wait_ff;
	assign avs_readdata_out = rdata_ff;
	assign line_control_out = lctl_ff;

	// Software must reprogram line control after divisor changes
	// and keep the low-power rate in its band; commit is unused
	wire unused_commit = bus_commit;

endmodule
`default_nettype wire

/* dv/ubd_divisors_sva.sv */
// Purpose: Port assertions for the UART divisor block
// Assumes: Every register write uses all byte enables
// Notes:   Shadows follow bus writes and divisor loads
`timescale 1ns/1ps
`default_nettype none
module ubd_divisors_sva
	import ubd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Bus
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	// Line side
	input wire logic tx_busy_in,
	input wire logic rx_busy_in,
	input wire logic ir_rx_in,
	input wire logic ir_tx_out,
	input wire logic ir_rx_valid_out,
	input wire logic baud_x16_tick_out,
	input wire logic low_power_x16_tick_out
);
	logic [7:0] ilp, gap, run;
	logic [15:0] ib, ai;
	logic [5:0] fb, af;
	logic pend, lpm, seen;
	wire go = avs_write_in && !avs_waitrequest_out;
	wire rdc = avs_read_in && !avs_waitrequest_out;
	wire [7:0] a = avs_address_in;
	wire [31:0] d = avs_writedata_in;
	wire lpt = low_power_x16_tick_out;
	// Load waits until neither direction is mid-character
	wire load = pend && !tx_busy_in && !rx_busy_in;

	// ==================================================================
	// Shadow state
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ilp <= ILP_RST;
			ib <= IBRD_RST;
			fb <= FBRD_RST;
			ai <= IBRD_RST;
			af <= FBRD_RST;
			pend <= 1'b0;
			lpm <= 1'b0;
			seen <= 1'b0;
		end else begin
			if (go && a == OFS_ILP) ilp <= d[7:0];
			if (go && a == OFS_IBRD) ib <= d[15:0];
			if (go && a == OFS_FBRD) fb <= d[5:0];
			if (go && a == OFS_IRCTL) lpm <= d[IRCTL_LP_BIT];
			if (load) begin
				ai <= ib;
				af <= fb;
			end
			// Set wins over the load that clears it
			pend <= (go && a == OFS_LCTL) || (pend && !load);
			// First tick after a divisor change may be irregular
			seen <= !(go && a == OFS_ILP) && (seen || lpt);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		gap <= lpt ? 8'h01 : gap + 8'h01;
		run <= ir_rx_in ? run + 8'h01 : 8'h00;
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	a_ilp_readback: assert property (
		rdc && a == OFS_ILP |-> avs_readdata_out == {24'h0, ilp})
		else $error("low-power divisor readback wrong");
	a_int_readback: assert property (
		rdc && a == OFS_IBRD |-> avs_readdata_out == {16'h0, ib})
		else $error("integer divisor readback wrong");
	a_active_load: assert property (
		rdc && a == OFS_ACT |-> avs_readdata_out == {10'h0, af, ai})
		else $error("active divisor loaded at wrong time");
	a_div_by_one: assert property (
		ai == 16'h0 ##1 ai == 16'h0 |-> baud_x16_tick_out)
		else $error("zero integer divisor missed a tick");
	a_lp_period: assert property (
		lpt && seen |-> gap == ilp)
		else $error("low-power tick spacing wrong");
	a_lp_zero_quiet: assert property (
		ilp == 8'h00 |=> !lpt)
		else $error("low-power tick with zero divisor");
	a_ir_pulse_len: assert property (
		$fell(ir_tx_out) && lpm && ilp == 8'h16
		|-> $past(ir_tx_out, 66) && !$past(ir_tx_out, 67))
		else $error("infrared pulse length wrong");
	a_rx_short_reject: assert property (
		$rose(ir_rx_valid_out) && lpm && ilp == 8'h16 |-> run >= 8'h15)
		else $error("short infrared pulse accepted");
endmodule

bind ubd_divisors ubd_divisors_sva u_sva (
	.ref_clk_in,
	.rst_b_in,
	.avs_address_in,
	.avs_read_in,
	.avs_write_in,
	.avs_writedata_in,
	.avs_readdata_out,
	.avs_waitrequest_out,
	.tx_busy_in,
	.rx_busy_in,
	.ir_rx_in,
	.ir_tx_out,
	.ir_rx_valid_out,
	.baud_x16_tick_out,
	.low_power_x16_tick_out
);
`default_nettype wire

/* dv/ubd_far_model.sv */
// Purpose: Serial engine and infrared transceiver stand-in
// Assumes: Driven only through its tasks
// Notes:   No light on the line when idle
`timescale 1ns/1ps
`default_nettype none
module ubd_far_model (
	// Clock
	input wire logic ref_clk_in,
	// Engine and line
	output logic tx_busy_out,
	output logic rx_busy_out,
	output logic zero_bit_out,
	output logic light_out
);
	initial begin
		tx_busy_out = 1'b0;
		rx_busy_out = 1'b0;
		zero_bit_out = 1'b0;
		light_out = 1'b0;
	end

	// Character in flight both ways for n cycles
	task automatic busy(input int n);
		@(posedge ref_clk_in);
		tx_busy_out <= 1'b1;
		rx_busy_out <= 1'b1;
		repeat (n) @(posedge ref_clk_in);
		tx_busy_out <= 1'b0;
		rx_busy_out <= 1'b0;
	endtask

	task automatic zero_bit();
		@(posedge ref_clk_in);
		zero_bit_out <= 1'b1;
		@(posedge ref_clk_in);
		zero_bit_out <= 1'b0;
	endtask

	task automatic light(input int n);
		@(posedge ref_clk_in);
		light_out <= 1'b1;
		repeat (n) @(posedge ref_clk_in);
		light_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for the UART divisor block
// Assumes: 40 MHz clock, full byte enables
// Notes:   Reads queue their expected data for the monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ubd_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, v, act;
	logic wq, tx_b, rx_b, zb, lt, irt, irv, bt, lpt;
	logic [7:0] lco;
	logic [31:0] exp_q[$];
	logic [7:0] ofs[6] = '{OFS_ILP, OFS_IBRD, OFS_FBRD, OFS_LCTL,
		OFS_ACT, 8'h3c};
	logic [31:0] msk[3] = '{32'hff, 32'hffff, 32'h3f};
	logic [15:0] ti[3] = '{16'h0, 16'h4, 16'h4};
	logic [5:0] tf[3] = '{6'h3f, 6'h20, 6'h00};
	int tw[3] = '{64, 72, 64};
	int tt[3] = '{64, 16, 16};
	int pw[2] = '{66, 12};
	int ln[2] = '{21, 60};
	int n_mismatch = 0;
	int num_checks = 0;
	int seed = 57301;
	int cb, cl, cv, i, k;

	always #12.5 ref_clk_in = ~ref_clk_in;

	ubd_divisors u_dut (
		.ref_clk_in, .rst_b_in,
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(4'hf),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wq),
		.tx_busy_in(tx_b), .rx_busy_in(rx_b), .ir_zero_bit_in(zb),
		.ir_rx_in(lt), .ir_tx_out(irt), .ir_rx_valid_out(irv),
		.baud_x16_tick_out(bt), .low_power_x16_tick_out(lpt),
		.line_control_out(lco)
	);
	ubd_far_model u_far (.ref_clk_in, .tx_busy_out(tx_b),
		.rx_busy_out(rx_b), .zero_bit_out(zb), .light_out(lt));

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge ref_clk_in);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		// Waitrequest is sampled at the rising edge, before it updates
		do @(posedge ref_clk_in); while (wq !== 1'b0 && ++t < 40);
		if (t >= 40) begin
			n_mismatch++;
			final_report();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rdx(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic sample(input int n);
		cb = 0;
		cl = 0;
		cv = 0;
		repeat (n) begin
			@(posedge ref_clk_in);
			cb += int'(bt);
			cl += int'(lpt);
			cv += int'(irv);
		end
	endtask

	always @(posedge ref_clk_in) begin
		if (rd && wq === 1'b0)
			check("readdata", rdat, exp_q.pop_front());
	end

	initial begin
		repeat (60000) @(posedge ref_clk_in);
		n_mismatch++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		foreach (ofs[i]) rdx(ofs[i], 32'h0);
		for (i = 0; i < 3; i++) begin
			v = $random(seed);
			bus(1'b1, ofs[i], v);
			rdx(ofs[i], v & msk[i]);
		end
		$display("test registers done");
		act = 32'h0;
		for (i = 0; i < 3; i++) begin
			fork
				u_far.busy(60);
				begin
					bus(1'b1, OFS_IBRD, {16'h0, ti[i]});
					bus(1'b1, OFS_FBRD, {26'h0, tf[i]});
					rdx(OFS_ACT, act);
					bus(1'b1, OFS_LCTL, 32'h60);
					rdx(OFS_ACT, act);
				end
			join
			act = {10'h0, tf[i], ti[i]};
			rdx(OFS_ACT, act);
			sample(tw[i]);
			check("baud_ticks", cb, tt[i]);
		end
		check("line_control", {24'h0, lco}, 32'h60);
		$display("test divisor load done");
		bus(1'b1, OFS_ILP, 32'h0);
		repeat (4) @(posedge ref_clk_in);
		sample(300);
		check("lp_ticks_zero", cl, 0);
		bus(1'b1, OFS_ILP, 32'h16);
		// Old count restarts at once when at or past the new end
		repeat (300) @(posedge ref_clk_in);
		sample(220);
		check("lp_ticks", cl, 10);
		$display("test low-power clock done");
		for (i = 0; i < 2; i++) begin
			bus(1'b1, OFS_IRCTL, {30'h0, i == 0, 1'b1});
			u_far.zero_bit();
			for (k = 0; k < 300 && irt !== 1'b1; k++)
				@(posedge ref_clk_in);
			for (k = 0; k < 300 && irt === 1'b1; k++)
				@(posedge ref_clk_in);
			check("ir_pulse", k, pw[i]);
		end
		$display("test infrared pulse done");
		bus(1'b1, OFS_IRCTL, 32'h3);
		for (i = 0; i < 2; i++) begin
			fork
				u_far.light(ln[i]);
				sample(ln[i] + 4);
			join
			check("rx_valid", cv != 0, i);
		end
		$display("test infrared receive done");
		repeat (4) @(posedge ref_clk_in);
		final_report();
	end
endmodule
`default_nettype wire
